// >>> bench/sos_top_asserts.sv
// Concurrent checks on the standby controller ports.
// Assumes one clock domain; bound onto sos_top below.
`timescale 1ns/10ps
`default_nettype none
`include "sos_regs.svh"

module sos_top_asserts
   import sos_pkg::*;
#(
   parameter int STAB_SHIFT = 0 // Crystal wait shortening
) (
   input wire logic            clk,               // System clock
   input wire logic            resetn,            // Reset, active low
   input wire sos_bus_req_type bus_req,           // CPU access
   input wire logic [7:0]      rdata_ff,          // Read data
   input wire logic            rvalid_ff,         // Read valid
   input wire logic            idle_exec,         // Idle instruction
   input wire logic            sleep_exec,        // Sleep instruction
   input wire logic            irq_req,           // Interrupt request
   input wire logic            cpu_on_xtal,       // CPU on crystal
   input wire logic            main_osc_stop_bit, // Crystal stop
   input wire logic            cpu_clk_en_ff,     // CPU clock enable
   input wire sos_osc_type     osc_en_ff,         // Oscillator enables
   input wire logic            standby_ff,        // Standby level
   input wire logic            wake_ff            // Wake pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Decoded reads; run means clock on and no standby
   wire logic st_rd = bus_req.rd && bus_req.addr == `SOS_ADDR_STATUS;
   wire logic se_rd = bus_req.rd && bus_req.addr == `SOS_ADDR_SELECT;
   wire logic run   = cpu_clk_en_ff && !standby_ff;

   sequence idle_in_s;
      run && idle_exec && !sleep_exec;
   endsequence
   sequence sleep_in_s;
      run && sleep_exec;
   endsequence
   sequence stop_held_s;
      main_osc_stop_bit ##1 main_osc_stop_bit && st_rd && !bus_req.bit_acc;
   endsequence

   rd_answer_a: assert property ((st_rd || se_rd) |=> rvalid_ff)
      else $error("mapped read without valid");
   unmapped_quiet_a: assert property (bus_req.rd && !st_rd && !se_rd
      |=> !rvalid_ff && rdata_ff == 8'h00) else $error("unmapped read answered");
   status_upper_a: assert property (st_rd && !bus_req.bit_acc
      |=> rdata_ff[7:5] == 3'h0) else $error("status upper bits set");
   select_upper_a: assert property (se_rd && !bus_req.bit_acc
      |=> rdata_ff[7:3] == 5'h00) else $error("select upper bits set");
   bit_read_a: assert property ((st_rd || se_rd) && bus_req.bit_acc
      |=> rdata_ff[7:1] == 7'h00) else $error("bit read wider than one bit");
   idle_gate_a: assert property (idle_in_s |=> !cpu_clk_en_ff &&
      standby_ff && osc_en_ff == $past(osc_en_ff)) else $error("idle entry");
   sleep_stop_a: assert property (sleep_in_s |=> !cpu_clk_en_ff &&
      standby_ff && !osc_en_ff.xtal && !osc_en_ff.ihs) else $error("sleep");
   fast_wake_a: assert property (standby_ff && irq_req
      && !cpu_on_xtal |=> wake_ff && run) else $error("no prompt wake");
   // Both main oscillators off marks deep sleep, not an idle with ihs off
   xtal_wait_a: assert property (standby_ff && !osc_en_ff.ihs &&
      !osc_en_ff.xtal && irq_req && cpu_on_xtal |=> !cpu_clk_en_ff [*8])
      else $error("wait skipped");
   wake_pulse_a: assert property (wake_ff |-> run ##1 !wake_ff)
      else $error("wake pulse malformed");
   osc_stop_clr_a: assert property (stop_held_s |=> rdata_ff == 8'h00)
      else $error("status kept under oscillator stop");
endmodule

bind sos_top sos_top_asserts #(.STAB_SHIFT(STAB_SHIFT)) u_sos_top_asserts (
   .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata_ff(rdata_ff),
   .rvalid_ff(rvalid_ff), .idle_exec(idle_exec), .sleep_exec(sleep_exec),
   .irq_req(irq_req), .cpu_on_xtal(cpu_on_xtal),
   .main_osc_stop_bit(main_osc_stop_bit), .cpu_clk_en_ff(cpu_clk_en_ff),
   .osc_en_ff(osc_en_ff), .standby_ff(standby_ff), .wake_ff(wake_ff)
);
`default_nettype wire

// >>> bench/sos_xtal_model.sv
// Behavioural crystal oscillator beside the standby controller.
// Assumes its enable comes from the device's crystal enable output.
`timescale 1ns/10ps
`default_nettype none

module sos_xtal_model #(
   parameter int START = 20, // Cycles before oscillation appears
   parameter int HALF  = 4   // Crystal half period in clk cycles
) (
   input  wire logic clk,         // System clock
   input  wire logic resetn,      // Async reset, active low
   input  wire logic en,          // Oscillator enable from the device
   output logic      xtal_clk_ff, // Crystal clock, low while stopped
   output logic      osc_ok_ff    // Oscillation present
);
   int cnt_ff;

   // Startup gap, then free running; a stopped crystal stands low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn || !en) begin
         cnt_ff <= 0;
         xtal_clk_ff <= 1'b0;
         osc_ok_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 1;
         osc_ok_ff <= (cnt_ff >= START);
         if (cnt_ff >= START && cnt_ff % HALF == 0) begin
            xtal_clk_ff <= ~xtal_clk_ff;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/standby_osc_stabilization_test.sv
// Self-checking bench for the standby controller and its counter.
// Assumes the crystal model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "sos_regs.svh"

module standby_osc_stabilization_test;
   import sos_pkg::*;
   localparam int SH = 8; // Waits shrink to 2^3..2^8 crystal edges
   logic            clk               = 1'b0;
   logic            resetn            = 1'b0;
   sos_bus_req_type bus_req           = '0;
   logic            idle_exec         = 1'b0;
   logic            sleep_exec        = 1'b0;
   logic            irq_req           = 1'b0;
   logic            cpu_on_xtal       = 1'b1;
   logic            main_osc_stop_bit = 1'b0;
   logic            xtal_clk, xtal_ok, rvalid_ff, cpu_clk_en_ff;
   logic            standby_ff, wake_ff;
   logic [7:0]      rdata_ff;
   sos_osc_type     osc_en_ff;
   logic [7:0]      expq[$];
   int              num_errors        = 0;
   int              n_tests           = 0;
   int              cycles            = 0;

   always #2.5 clk = ~clk;

   sos_top #(.STAB_SHIFT(SH)) u_sos_top (
      .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata_ff(rdata_ff),
      .rvalid_ff(rvalid_ff), .idle_exec(idle_exec), .sleep_exec(sleep_exec),
      .irq_req(irq_req), .cpu_on_xtal(cpu_on_xtal),
      .main_osc_stop_bit(main_osc_stop_bit), .osc_run_req(3'b111),
      .xtal_clk(xtal_clk), .xtal_osc_ok(xtal_ok),
      .cpu_clk_en_ff(cpu_clk_en_ff), .osc_en_ff(osc_en_ff),
      .standby_ff(standby_ff), .wake_ff(wake_ff));

   sos_xtal_model u_sos_xtal_model (
      .clk(clk), .resetn(resetn), .en(osc_en_ff.xtal),
      .xtal_clk_ff(xtal_clk), .osc_ok_ff(xtal_ok));

   task automatic chk(logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic wrap_up();
      if (expq.size() != 0) num_errors++;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Read results are matched oldest first; a stray valid is an error
   always @(posedge clk) begin
      if (rvalid_ff === 1'b1) begin
         if (expq.size() == 0) chk(8'hee, rdata_ff);
         else chk(expq.pop_front(), rdata_ff);
      end
   end

   // Hang guard well above the longest expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles > 30000) begin
         num_errors++;
         wrap_up();
      end
   end

   // One register access; d is write data or bit number, ev the read value
   task automatic acc(bit rd, bit ba, logic [15:0] a, logic [7:0] d,
                      bit ex, logic [7:0] ev);
      bus_req.addr <= a;
      bus_req.rd <= rd;
      bus_req.wr <= !rd;
      bus_req.bit_acc <= ba;
      bus_req.bit_idx <= d[2:0];
      bus_req.wdata <= d;
      if (rd && ex) expq.push_back(ev);
      @(posedge clk);
      bus_req.rd <= 1'b0;
      bus_req.wr <= 1'b0;
      @(posedge clk);
   endtask

   // One-cycle instruction strobe; slp picks deep sleep, else idle
   task automatic pulse(bit slp);
      if (slp) sleep_exec <= 1'b1;
      else idle_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      idle_exec <= 1'b0;
      @(posedge clk);
   endtask

   // Wake is awaited under a bound; n returns the cycles spent
   task automatic wake_wait(output int n);
      n = 0;
      while (wake_ff !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      irq_req <= 1'b0;
      if (n >= 5000) chk(8'h01, 8'h00);
   endtask

   initial begin
      int n;
      int e;
      void'($urandom(84513));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      acc(1, 0, `SOS_ADDR_STATUS, 0, 1, `SOS_STATUS_RESET);
      acc(1, 0, `SOS_ADDR_SELECT, 0, 1, `SOS_SELECT_RESET);
      acc(0, 0, `SOS_ADDR_STATUS, 8'hff, 0, 0);
      acc(1, 0, `SOS_ADDR_STATUS, 0, 1, 8'h00);
      acc(0, 1, `SOS_ADDR_SELECT, 8'h00, 0, 0);
      acc(1, 0, `SOS_ADDR_SELECT, 0, 1, 8'h05);
      acc(1, 0, 16'hffa5, 0, 0, 0);
      $display("test registers done");
      repeat (2300) @(posedge clk);
      for (int b = 0; b < 8; b++) acc(1, 1, `SOS_ADDR_STATUS, 8'(b), 1,
                                      8'(b < 5));
      acc(1, 0, `SOS_ADDR_STATUS, 0, 1, 8'h1f);
      main_osc_stop_bit <= 1'b1;
      @(posedge clk);
      acc(1, 0, `SOS_ADDR_STATUS, 0, 1, 8'h00);
      main_osc_stop_bit <= 1'b0;
      $display("test counting done");
      for (int k = 1; k <= 5; k++) begin
         e = (k == 1) ? 11 : 11 + k;
         acc(0, 0, `SOS_ADDR_SELECT, {5'($urandom), 3'(k)}, 0, 0);
         acc(1, 0, `SOS_ADDR_SELECT, 0, 1, 8'(k));
         // No main-clock peripheral, converter or amplifier runs here
         pulse(1'b1);
         chk(8'h00, 8'(cpu_clk_en_ff));
         irq_req <= 1'b1;
         wake_wait(n);
         chk(8'h01, 8'(n >= (8 << (e - SH))));
         repeat (4) @(posedge clk);
         acc(1, 0, `SOS_ADDR_STATUS, 0, 1,
             8'((8'h1f << (5 - k)) & 8'h1f));
      end
      $display("test crystal sleep done");
      cpu_on_xtal <= 1'b0;
      pulse(1'b1);
      irq_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(8'h01, 8'(wake_ff));
      irq_req <= 1'b0;
      acc(1, 0, `SOS_ADDR_STATUS, 0, 1, 8'h00);
      pulse(1'b0);
      chk(8'h00, 8'(cpu_clk_en_ff));
      chk(8'h07, 8'(osc_en_ff));
      chk(8'h01, 8'(standby_ff));
      irq_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(8'h01, 8'(wake_ff));
      irq_req <= 1'b0;
      acc(1, 0, `SOS_ADDR_SELECT, 0, 1, 8'h05);
      $display("test internal clock and idle done");
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> common/sos_pkg.sv
// Types shared by the standby controller and its stabilization counter.
// Assumes the constants header is compiled alongside.
package sos_pkg;

   // Standby sequencer states, one-hot
   typedef enum logic [3:0] {
      SOS_RUN  = 4'b0001,
      SOS_IDLE = 4'b0010,
      SOS_STOP = 4'b0100,
      SOS_WAIT = 4'b1000
   } sos_state_type;

   // CPU data-space access, one cycle wide
   typedef struct packed {
      logic [15:0] addr;    // Byte address
      logic        rd;      // Read strobe
      logic        wr;      // Write strobe
      logic        bit_acc; // 1 = single-bit access, 0 = 8-bit access
      logic [2:0]  bit_idx; // Bit number for single-bit access
      logic [7:0]  wdata;   // Write data (bit access uses wdata[0])
   } sos_bus_req_type;

   // Oscillator enables
   typedef struct packed {
      logic xtal; // Crystal oscillator
      logic ihs;  // Internal high-speed oscillator
      logic ils;  // Internal low-speed oscillator
   } sos_osc_type;

endpackage

// >>> common/sos_regs.svh
// Register map, field positions, reset values and counter figures of the
// standby and oscillation stabilization controller.
// Assumes a CPU data space with 16-bit byte addresses.
`ifndef SOS_REGS_SVH
`define SOS_REGS_SVH

// Register byte addresses in the CPU data space
`define SOS_ADDR_STATUS   16'hffa3
`define SOS_ADDR_SELECT   16'hffa4

// Reset values
`define SOS_STATUS_RESET  8'h00
`define SOS_SELECT_RESET  8'h05

// Select field: bits 2..0, upper bits read zero
`define SOS_SEL_W         3
`define SOS_SEL_CODE_S1   3'h1
`define SOS_SEL_CODE_S2   3'h2
`define SOS_SEL_CODE_S3   3'h3
`define SOS_SEL_CODE_S4   3'h4
`define SOS_SEL_CODE_S5   3'h5

// Status field: five thermometer flags in bits 4..0, stage 1 in bit 4
`define SOS_STAGES        5
`define SOS_STAT_BIT_S1   4
`define SOS_STAT_BIT_S5   0

// Wait lengths as powers of two of crystal cycles
`define SOS_EXP_S1        5'd11
`define SOS_EXP_S2        5'd13
`define SOS_EXP_S3        5'd14
`define SOS_EXP_S4        5'd15
`define SOS_EXP_S5        5'd16

// Counter width covers 2^16 crystal cycles
`define SOS_CNT_W         17

`endif

// >>> rtl/sos_stab_cnt.sv
// Crystal oscillation stabilization counter with thermometer status flags.
// Assumes count_en is a one-cycle pulse per crystal cycle, on clk.
`timescale 1ns/10ps
`default_nettype none
`include "sos_regs.svh"

module sos_stab_cnt
   import sos_pkg::*;
#(
   parameter int CNT_W = `SOS_CNT_W,
   parameter int SHIFT = 0
) (
   input  wire logic                  clk,      // 200 MHz system clock
   input  wire logic                  resetn,   // Async reset, active low
   input  wire logic                  clear,    // Clear count and flags
   input  wire logic                  count_en, // One crystal cycle seen
   input  wire logic [`SOS_SEL_W-1:0] sel,      // Wait length code
   output logic [`SOS_STAGES-1:0]     flags_ff, // Status, stage 1 in MSB
   output logic                       done_ff   // Selected length reached
);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] limit;

   // Exponent of a select code; prohibited codes fall back to the longest
   function automatic logic [4:0] sel_exp(input logic [`SOS_SEL_W-1:0] s);
      unique case (s)
         `SOS_SEL_CODE_S1: sel_exp = `SOS_EXP_S1;
         `SOS_SEL_CODE_S2: sel_exp = `SOS_EXP_S2;
         `SOS_SEL_CODE_S3: sel_exp = `SOS_EXP_S3;
         `SOS_SEL_CODE_S4: sel_exp = `SOS_EXP_S4;
         default:          sel_exp = `SOS_EXP_S5;
      endcase
   endfunction

   // Exponent of status stage i, stage 0 being the shortest
   function automatic logic [4:0] stage_exp(input int i);
      unique case (i)
         0:       stage_exp = `SOS_EXP_S1;
         1:       stage_exp = `SOS_EXP_S2;
         2:       stage_exp = `SOS_EXP_S3;
         3:       stage_exp = `SOS_EXP_S4;
         default: stage_exp = `SOS_EXP_S5;
      endcase
   endfunction

   // Cycle count for an exponent; SHIFT shortens all waits for simulation
   function automatic logic [CNT_W-1:0] thresh(input logic [4:0] e);
      int sh;
      sh = int'(e) - SHIFT;
      if (sh < 0) begin
         sh = 0;
      end
      thresh = {{(CNT_W-1){1'b0}}, 1'b1} << sh;
   endfunction

   assign limit = thresh(sel_exp(sel));

   // Count crystal cycles, saturating at the selected length
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else if (clear) begin
         cnt_ff <= '0;
      end else if (count_en && cnt_ff < limit) begin
         cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Thermometer flags; sticky until cleared, never beyond the limit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_ff <= '0;
      end else if (clear) begin
         flags_ff <= '0;
      end else begin
         for (int i = 0; i < `SOS_STAGES; i++) begin
            if (cnt_ff >= thresh(stage_exp(i))) begin
               flags_ff[`SOS_STAT_BIT_S1-i] <= 1'b1;
            end
         end
      end
   end

   // Wait complete once the saturated count equals the limit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= !clear && (cnt_ff >= limit);
      end
   end

endmodule
`default_nettype wire

// >>> rtl/sos_top.sv
// Standby controller: idle and deep-sleep sequencing, oscillator gating,
// and the stabilization status and select registers.
// Assumes CPU strobes, interrupt request and clock-select levels are on clk;
// the crystal clock and its oscillation-present level arrive as pins.
//
// Function
// - Idle instruction gates only the CPU clock
// - Running oscillators keep running in idle mode
// - Deep sleep stops crystal and internal high-speed oscillators
// - Interrupt request ends deep sleep
// - Registers and memory held during both standby modes
// - Port latches and buffers held during standby
// - Status register read-only, bit or byte reads
// - Five sticky thermometer bits, upper bits zero
// - Counting ends at selected wait length
// - Crystal-clocked CPU waits selected time after deep-sleep wake
// - Select codes one to five map to lengths
// - Select resets 05h, byte writes only, bits 2..0
// - Counting starts only once crystal oscillates
// - Unmasked interrupt ends idle mode
`timescale 1ns/10ps
`default_nettype none
`include "sos_regs.svh"

module sos_top
   import sos_pkg::*;
#(
   parameter int STAB_SHIFT = 0 // Shortens crystal waits by 2^STAB_SHIFT
) (
   input  wire logic            clk,           // 200 MHz system clock
   input  wire logic            resetn,        // Any chip reset, active low
   input  wire sos_bus_req_type bus_req,       // CPU register access
   output logic [7:0]           rdata_ff,      // Read data
   output logic                 rvalid_ff,     // Read data valid, pulse
   input  wire logic            idle_exec,     // Idle instruction, pulse
   input  wire logic            sleep_exec,    // Deep-sleep instruction
   input  wire logic            irq_req,       // Unmasked interrupt level
   input  wire logic            cpu_on_xtal,   // 1 = CPU runs on crystal
   input  wire logic            main_osc_stop_bit, // Crystal stop request
   input  wire sos_osc_type     osc_run_req,   // Oscillators software runs
   input  wire logic            xtal_clk,      // Crystal clock pin
   input  wire logic            xtal_osc_ok,   // Oscillation present pin
   output logic                 cpu_clk_en_ff, // CPU clock gate enable
   output sos_osc_type          osc_en_ff,     // Oscillator enables
   output logic                 standby_ff,    // Hold latches and buffers
   output logic                 wake_ff        // Standby ended, pulse
);

   sos_state_type          state_ff;
   sos_state_type          nxt_state;
   logic [`SOS_SEL_W-1:0]  sel_ff;
   logic [`SOS_STAGES-1:0] flags;
   logic                   stab_done;
   logic                   cnt_clear;
   logic                   cnt_en;
   logic                   xclk_s1_ff;
   logic                   xclk_s2_ff;
   logic                   xclk_d_ff;
   logic                   ok_s1_ff;
   logic                   ok_s2_ff;
   logic [7:0]             status_byte;
   logic [7:0]             select_byte;
   logic                   hit_status;
   logic                   hit_select;

   // Full reset byte; only the select field is kept in the register
   localparam logic [7:0] SEL_RESET = `SOS_SELECT_RESET;

   // Pin synchronisers; the first stages feed only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xclk_s1_ff <= 1'b0;
         xclk_s2_ff <= 1'b0;
         xclk_d_ff  <= 1'b0;
         ok_s1_ff   <= 1'b0;
         ok_s2_ff   <= 1'b0;
      end else begin
         xclk_s1_ff <= xtal_clk;
         xclk_s2_ff <= xclk_s1_ff;
         xclk_d_ff  <= xclk_s2_ff;
         ok_s1_ff   <= xtal_osc_ok;
         ok_s2_ff   <= ok_s1_ff;
      end
   end

   // Crystal rising edges count only while it oscillates and is enabled;
   // start-up time before oscillation is thereby excluded
   assign cnt_en = xclk_s2_ff && !xclk_d_ff && ok_s2_ff
                   && osc_en_ff.xtal;

   // Deep-sleep entry or a crystal stop request wipes the status
   assign cnt_clear = (state_ff == SOS_RUN && sleep_exec)
                      || main_osc_stop_bit;

   // Standby sequencer next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SOS_RUN: begin
            if (sleep_exec) begin
               nxt_state = SOS_STOP;
            end else if (idle_exec) begin
               nxt_state = SOS_IDLE;
            end
         end
         SOS_IDLE: begin
            if (irq_req) begin
               nxt_state = SOS_RUN;
            end
         end
         SOS_STOP: begin
            if (irq_req) begin
               // Internal clock needs no crystal wait
               nxt_state = cpu_on_xtal ? SOS_WAIT : SOS_RUN;
            end
         end
         SOS_WAIT: begin
            if (stab_done) begin
               nxt_state = SOS_RUN;
            end
         end
         default: nxt_state = SOS_RUN;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= SOS_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Clock gating from the next state, so outputs are pure flops.
   // Only the CPU loses its clock in idle; registers and memory
   // simply stop changing, which is what preserves them.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_clk_en_ff <= 1'b1;
         standby_ff    <= 1'b0;
      end else begin
         cpu_clk_en_ff <= (nxt_state == SOS_RUN);
         standby_ff    <= (nxt_state != SOS_RUN);
      end
   end

   // Oscillator enables follow software in idle; crystal and ihs forced off in deep sleep, ils follows software
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         osc_en_ff <= '0;
      end else begin
         osc_en_ff.xtal <= osc_run_req.xtal
                           && (nxt_state != SOS_STOP);
         osc_en_ff.ihs  <= osc_run_req.ihs
                           && (nxt_state != SOS_STOP);
         osc_en_ff.ils  <= osc_run_req.ils;
      end
   end

   // Wake pulse on return to run from either standby mode
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= (state_ff != SOS_RUN) && (nxt_state == SOS_RUN);
      end
   end

   // Stabilization counter and status flags
   sos_stab_cnt #(
      .CNT_W (`SOS_CNT_W),
      .SHIFT (STAB_SHIFT)
   ) u_stab_cnt (
      .clk      (clk),
      .resetn   (resetn),
      .clear    (cnt_clear),
      .count_en (cnt_en),
      .sel      (sel_ff),
      .flags_ff (flags),
      .done_ff  (stab_done)
   );

   // Address decode and read views; unused upper bits read zero
   assign hit_status  = (bus_req.addr == `SOS_ADDR_STATUS);
   assign hit_select  = (bus_req.addr == `SOS_ADDR_SELECT);
   assign status_byte = {3'h0, flags};
   assign select_byte = {5'h00, sel_ff};

   // Select register: byte writes only; bit writes are ignored.
   // Changing it mid-wait moves the limit, which software must avoid.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_ff <= SEL_RESET[`SOS_SEL_W-1:0];
      end else if (bus_req.wr && hit_select && !bus_req.bit_acc) begin
         sel_ff <= bus_req.wdata[`SOS_SEL_W-1:0];
      end
   end

   // Register reads; the status register ignores every write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= bus_req.rd && (hit_status || hit_select);
         if (bus_req.rd && hit_status) begin
            rdata_ff <= bus_req.bit_acc
                        ? {7'h00, status_byte[bus_req.bit_idx]}
                        : status_byte;
         end else if (bus_req.rd && hit_select) begin
            rdata_ff <= bus_req.bit_acc
                        ? {7'h00, select_byte[bus_req.bit_idx]}
                        : select_byte;
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

endmodule
`default_nettype wire
